//--- core/ipc_consts.vh
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH

// ==========================================
// Register byte offsets
`define IPC_OFF_PRIO1 8'h00
`define IPC_OFF_PRIO2 8'h04
`define IPC_OFF_PRIO3 8'h08
`define IPC_OFF_RCAUSE 8'h0C
`define IPC_OFF_MAIN 8'h10
`define IPC_OFF_SECOND 8'h14
`define IPC_OFF_THIRD 8'h18
`define IPC_OFF_TMR0CFG 8'h1C
`define IPC_OFF_STATUS 8'h20

// ==========================================
// Reset values and the priority-2 mask
`define IPC_RST_PRIO1 8'hFF
`define IPC_RST_PRIO2 8'hCB
`define IPC_RST_PRIO3 8'hFF
`define IPC_RST_RCAUSE 8'h1C
`define IPC_RST_MAIN 8'h00
`define IPC_RST_SECOND 8'h7F
`define IPC_RST_THIRD 8'hC0
`define IPC_PRIO2_MASK 8'hCB

// ==========================================
// Reset cause control fields
`define IPC_RC_PRIO_EN 7
`define IPC_RC_INSTR 4
`define IPC_RC_WDT 3
`define IPC_RC_PWR_DOWN 2
`define IPC_RC_POR 1
`define IPC_RC_BROWN_OUT 0

// ==========================================
// Main control fields
`define IPC_MC_GLOBAL_EN 7
`define IPC_MC_PERIPH_EN 6
`define IPC_MC_T0_EN 5
`define IPC_MC_X0_EN 4
`define IPC_MC_RB_EN 3
`define IPC_MC_T0_FLAG 2
`define IPC_MC_X0_FLAG 1
`define IPC_MC_RB_FLAG 0

// ==========================================
// Second control fields (edge selects at 6..3 for pins 0..3)
`define IPC_SC_EDGE0 6
`define IPC_SC_T0_PRIO 2
`define IPC_SC_X3_PRIO 1
`define IPC_SC_RB_PRIO 0

// ==========================================
// Third control fields (enables 3..5, flags 0..2 for pins 1..3)
`define IPC_TC_X2_PRIO 7
`define IPC_TC_X1_PRIO 6
`define IPC_TC_EN1 3
`define IPC_TC_FLAG1 0

// ==========================================
// Return stack geometry
`define IPC_STK_DEPTH 31
`define IPC_STK_AW 5
`define IPC_PC_W 21

`endif

//--- core/ipc_irq_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_irq_ctrl (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] periph_flag_1,
  input wire [7:0] periph_flag_2,
  input wire [7:0] periph_flag_3,
  input wire [7:0] periph_en_1,
  input wire [7:0] periph_en_2,
  input wire [7:0] periph_en_3,
  input wire [3:0] ext_pin,
  input wire [3:0] portb_hi_pin,
  input wire [15:0] timer0_count,
  input wire instr_reset_evt,
  input wire watchdog_timeout_evt,
  input wire sleep_entry_evt,
  input wire watchdog_clear_evt,
  input wire por_evt,
  input wire brown_out_evt,
  input wire core_sleeping,
  input wire irq_taken,
  input wire return_evt,
  input wire [`IPC_PC_W-1:0] return_pc,
  input wire [7:0] working_register,
  input wire [7:0] status_register,
  input wire [3:0] bank_select_register,
  output reg irq_high_r,
  output reg irq_low_r,
  output reg wake_r,
  output reg wake_vector_r,
  output reg [7:0] shadow_working_r,
  output reg [7:0] shadow_status_r,
  output reg [3:0] shadow_bank_r,
  output wire [`IPC_PC_W-1:0] stack_top_r,
  output wire stack_overflow_r
);
  // ==========================================
  // Reset release
  reg [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // ==========================================
  // Registers
  reg [7:0] prio1_r;
  reg [7:0] prio2_r;
  reg [7:0] prio3_r;
  reg [7:0] rcause_r;
  reg [7:0] main_r;
  reg [7:0] second_r;
  reg [7:0] third_r;
  reg t0_wide_r;
  reg [7:0] rcause_nxt;
  reg [7:0] main_nxt;
  reg [7:0] third_nxt;
  reg [31:0] rd_nxt;
  reg map_hit;
  wire [4:0] stack_level;

  wire setup = psel && !penable;
  wire wr_ok = psel && penable && pready && pwrite;
  wire prio_en = rcause_r[`IPC_RC_PRIO_EN];

  // ==========================================
  // Pin synchronisers: eight pins, three stages, accept when 2 and 3 agree
  wire [7:0] pins_in = {portb_hi_pin, ext_pin};
  reg [7:0] pin_s1_r;
  reg [7:0] pin_s2_r;
  reg [7:0] pin_s3_r;
  reg [7:0] pin_q_r;
  reg [7:0] pin_prev_r;
  wire [3:0] ext_edge;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_r[i] <= 1'b0;
          pin_s2_r[i] <= 1'b0;
          pin_s3_r[i] <= 1'b0;
          pin_q_r[i] <= 1'b0;
          pin_prev_r[i] <= 1'b0;
        end else begin
          pin_s1_r[i] <= pins_in[i];
          pin_s2_r[i] <= pin_s1_r[i];
          pin_s3_r[i] <= pin_s2_r[i];
          if (pin_s2_r[i] == pin_s3_r[i]) begin
            pin_q_r[i] <= pin_s3_r[i];
          end
          pin_prev_r[i] <= pin_q_r[i];
        end
      end
      if (i < 4) begin : g_edge
        // Edge select bits run downward from pin 0
        assign ext_edge[i] = second_r[`IPC_SC_EDGE0 - i] ?
          (pin_q_r[i] && !pin_prev_r[i]) :
          (!pin_q_r[i] && pin_prev_r[i]);
      end
    end
  endgenerate

  // Upper port B mismatch; the first cycle after reset compares equal zeros
  wire portb_change = |(pin_q_r[7:4] ^ pin_prev_r[7:4]);

  // ==========================================
  // Timer-0 wrap detect
  reg [15:0] t0_prev_r;
  wire t0_wrap = t0_wide_r ?
    (t0_prev_r == 16'hFFFF && timer0_count == 16'h0000) :
    (t0_prev_r[7:0] == 8'hFF && timer0_count[7:0] == 8'h00);

  // ==========================================
  // Next values: hardware set wins over a software write
  always @* begin
    main_nxt = wr_ok && paddr == `IPC_OFF_MAIN ? pwdata[7:0] : main_r;
    if (t0_wrap) begin
      main_nxt[`IPC_MC_T0_FLAG] = 1'b1;
    end
    if (ext_edge[0]) begin
      main_nxt[`IPC_MC_X0_FLAG] = 1'b1;
    end
    if (portb_change) begin
      main_nxt[`IPC_MC_RB_FLAG] = 1'b1;
    end
    third_nxt = wr_ok && paddr == `IPC_OFF_THIRD ? pwdata[7:0] : third_r;
    third_nxt[`IPC_TC_FLAG1 +: 3] = third_nxt[`IPC_TC_FLAG1 +: 3] | ext_edge[3:1];
    rcause_nxt = rcause_r;
    if (wr_ok && paddr == `IPC_OFF_RCAUSE) begin
      rcause_nxt[`IPC_RC_PRIO_EN] = pwdata[`IPC_RC_PRIO_EN];
      rcause_nxt[`IPC_RC_INSTR] = pwdata[`IPC_RC_INSTR];
      rcause_nxt[`IPC_RC_POR] = pwdata[`IPC_RC_POR];
      rcause_nxt[`IPC_RC_BROWN_OUT] = pwdata[`IPC_RC_BROWN_OUT];
    end
    // Cause flags are active low: an event clears, watchdog clear sets the WDT and power-down flags
    if (watchdog_clear_evt) begin
      rcause_nxt[`IPC_RC_WDT] = 1'b1;
      rcause_nxt[`IPC_RC_PWR_DOWN] = 1'b1;
    end
    if (instr_reset_evt) begin
      rcause_nxt[`IPC_RC_INSTR] = 1'b0;
    end
    if (watchdog_timeout_evt) begin
      rcause_nxt[`IPC_RC_WDT] = 1'b0;
    end
    if (sleep_entry_evt) begin
      rcause_nxt[`IPC_RC_PWR_DOWN] = 1'b0;
    end
    if (por_evt) begin
      rcause_nxt[`IPC_RC_POR] = 1'b0;
    end
    if (brown_out_evt) begin
      rcause_nxt[`IPC_RC_BROWN_OUT] = 1'b0;
    end
    rcause_nxt[6:5] = 2'b00;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prio1_r <= `IPC_RST_PRIO1;
      prio2_r <= `IPC_RST_PRIO2;
      prio3_r <= `IPC_RST_PRIO3;
      rcause_r <= `IPC_RST_RCAUSE;
      main_r <= `IPC_RST_MAIN;
      second_r <= `IPC_RST_SECOND;
      third_r <= `IPC_RST_THIRD;
      t0_wide_r <= 1'b0;
      t0_prev_r <= 16'h0000;
    end else begin
      if (wr_ok && paddr == `IPC_OFF_PRIO1) begin
        prio1_r <= pwdata[7:0];
      end
      if (wr_ok && paddr == `IPC_OFF_PRIO2) begin
        prio2_r <= pwdata[7:0] & `IPC_PRIO2_MASK;
      end
      if (wr_ok && paddr == `IPC_OFF_PRIO3) begin
        prio3_r <= pwdata[7:0];
      end
      if (wr_ok && paddr == `IPC_OFF_SECOND) begin
        second_r <= {1'b0, pwdata[6:0]};
      end
      if (wr_ok && paddr == `IPC_OFF_TMR0CFG) begin
        t0_wide_r <= pwdata[0];
      end
      rcause_r <= rcause_nxt;
      main_r <= main_nxt;
      third_r <= third_nxt;
      t0_prev_r <= timer0_count;
    end
  end

  // ==========================================
  // Request routing
  wire [7:0] p1_act = periph_flag_1 & periph_en_1;
  wire [7:0] p2_act = periph_flag_2 & periph_en_2 & `IPC_PRIO2_MASK;
  wire [7:0] p3_act = periph_flag_3 & periph_en_3;
  wire x0_act = main_r[`IPC_MC_X0_FLAG] && main_r[`IPC_MC_X0_EN];
  wire [2:0] x_act = third_r[`IPC_TC_FLAG1 +: 3] & third_r[`IPC_TC_EN1 +: 3];
  wire t0_act = main_r[`IPC_MC_T0_FLAG] && main_r[`IPC_MC_T0_EN];
  wire rb_act = main_r[`IPC_MC_RB_FLAG] && main_r[`IPC_MC_RB_EN];
  wire [2:0] x_prio = {second_r[`IPC_SC_X3_PRIO], third_r[`IPC_TC_X2_PRIO],
                       third_r[`IPC_TC_X1_PRIO]};

  wire per_hi = |(p1_act & prio1_r) | |(p2_act & prio2_r) | |(p3_act & prio3_r);
  wire per_lo = |(p1_act & ~prio1_r) | |(p2_act & ~prio2_r) | |(p3_act & ~prio3_r);
  wire core_hi = x0_act | |(x_act & x_prio) |
                 (t0_act & second_r[`IPC_SC_T0_PRIO]) |
                 (rb_act & second_r[`IPC_SC_RB_PRIO]);
  wire core_lo = |(x_act & ~x_prio) |
                 (t0_act & ~second_r[`IPC_SC_T0_PRIO]) |
                 (rb_act & ~second_r[`IPC_SC_RB_PRIO]);
  wire core_any = x0_act | (|x_act) | t0_act | rb_act;
  wire per_any = (|p1_act) | (|p2_act) | (|p3_act);
  wire global_irq_enable = main_r[`IPC_MC_GLOBAL_EN];
  wire peripheral_irq_enable = main_r[`IPC_MC_PERIPH_EN];
  // With levels on, bit 6 gates the whole low level instead of peripherals
  wire hi_nxt = prio_en ? (global_irq_enable & (core_hi | per_hi)) :
                (global_irq_enable & (core_any | (peripheral_irq_enable & per_any)));
  wire lo_nxt = prio_en & global_irq_enable & peripheral_irq_enable & (core_lo | per_lo);
  wire ext_wake = x0_act | (|x_act);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_high_r <= 1'b0;
      irq_low_r <= 1'b0;
      wake_r <= 1'b0;
      wake_vector_r <= 1'b0;
    end else begin
      irq_high_r <= hi_nxt;
      irq_low_r <= lo_nxt;
      wake_r <= core_sleeping && ext_wake;
      wake_vector_r <= core_sleeping && ext_wake && global_irq_enable;
    end
  end

  // ==========================================
  // Context saving
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shadow_working_r <= 8'h00;
      shadow_status_r <= 8'h00;
      shadow_bank_r <= 4'h0;
    end else if (irq_taken) begin
      shadow_working_r <= working_register;
      shadow_status_r <= status_register;
      shadow_bank_r <= bank_select_register;
    end
  end

  ipc_ret_stack u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(irq_taken),
    .pop(return_evt),
    .push_data(return_pc),
    .top_r(stack_top_r),
    .level_r(stack_level),
    .overflow_r(stack_overflow_r)
  );

  // ==========================================
  // APB slave: answers in the first access cycle
  // Read data are latched at setup, so no wait state is ever inserted;
  // the price is that a read shows the register one cycle before access
  always @* begin
    rd_nxt = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
      `IPC_OFF_PRIO1: rd_nxt[7:0] = prio1_r;
      `IPC_OFF_PRIO2: rd_nxt[7:0] = prio2_r & `IPC_PRIO2_MASK;
      `IPC_OFF_PRIO3: rd_nxt[7:0] = prio3_r;
      `IPC_OFF_RCAUSE: rd_nxt[7:0] = rcause_r;
      `IPC_OFF_MAIN: rd_nxt[7:0] = main_r;
      `IPC_OFF_SECOND: rd_nxt[7:0] = second_r;
      `IPC_OFF_THIRD: rd_nxt[7:0] = third_r;
      `IPC_OFF_TMR0CFG: rd_nxt[0] = t0_wide_r;
      `IPC_OFF_STATUS: rd_nxt[8:0] = {stack_overflow_r, stack_level, wake_r,
                                      irq_low_r, irq_high_r};
      default: map_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr <= !map_hit || (pwrite && paddr == `IPC_OFF_STATUS);
      end else if (pready) begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule // ipc_irq_ctrl

`default_nettype wire

//--- core/ipc_ret_stack.v
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_ret_stack (
  input wire clk_sys,
  input wire rst_n,
  input wire push,
  input wire pop,
  input wire [`IPC_PC_W-1:0] push_data,
  output reg [`IPC_PC_W-1:0] top_r,
  output reg [`IPC_STK_AW-1:0] level_r,
  output reg overflow_r
);
  reg [`IPC_PC_W-1:0] mem [0:`IPC_STK_DEPTH-1];
  wire full = (level_r == `IPC_STK_DEPTH);
  wire [`IPC_STK_AW-1:0] below = level_r - 5'h2;

  // A push onto a full stack is dropped; the flag stays until reset
  always @(posedge clk_sys) begin
    if (push && !full) begin
      mem[level_r] <= push_data;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      top_r <= 21'h0_0000;
      level_r <= 5'h0;
      overflow_r <= 1'b0;
    end else if (push) begin
      if (full) begin
        overflow_r <= 1'b1;
      end else begin
        top_r <= push_data;
        level_r <= level_r + 5'h1;
      end
    end else if (pop && level_r != 5'h0) begin
      level_r <= level_r - 5'h1;
      top_r <= (level_r > 5'h1) ? mem[below] : 21'h0_0000;
    end
  end
endmodule // ipc_ret_stack

`default_nettype wire

//--- verif/ipc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

// ==========
// Core side: takes any request, services it for lat+1 cycles, then returns
module ipc_core_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic irq_high_r,
  input wire logic irq_low_r,
  output logic irq_taken,
  output logic return_evt,
  output logic [`IPC_PC_W-1:0] return_pc,
  output logic [7:0] working_register,
  output logic [7:0] status_register,
  output logic [3:0] bank_select_register
);
  logic busy_r;
  logic [3:0] cnt_r;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_taken <= 1'b0;
      return_evt <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      return_pc <= 21'h0_1000;
      working_register <= 8'h5A;
      status_register <= 8'h13;
      bank_select_register <= 4'h3;
    end else begin
      irq_taken <= 1'b0;
      return_evt <= 1'b0;
      // Context changes every cycle, not just with the take pulse, so it never sits still
      working_register <= ~working_register;
      status_register <= status_register + 8'h01;
      bank_select_register <= ~bank_select_register;
      if (!busy_r && (irq_high_r || irq_low_r)) begin
        irq_taken <= 1'b1;
        busy_r <= 1'b1;
        cnt_r <= lat;
        return_pc <= return_pc + 21'h0_0006;
      end else if (busy_r && cnt_r == 4'h0) begin
        return_evt <= 1'b1;
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule // ipc_core_model
`default_nettype wire

//--- verif/ipc_irq_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_irq_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_sleeping,
  input wire logic irq_taken,
  input wire logic return_evt,
  input wire logic [20:0] return_pc,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_register,
  input wire logic [3:0] bank_select_register,
  input wire logic irq_low_r,
  input wire logic wake_r,
  input wire logic wake_vector_r,
  input wire logic [7:0] shadow_working_r,
  input wire logic [7:0] shadow_status_r,
  input wire logic [3:0] shadow_bank_r,
  input wire logic [20:0] stack_top_r,
  input wire logic stack_overflow_r
);
  logic lvl_r;
  logic acc;
  assign acc = psel && penable && pready;
  // ==========
  // Level-enable bit rebuilt from bus writes, the design's copy is hidden
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lvl_r <= 1'b0;
    end else if (acc && pwrite && paddr == `IPC_OFF_RCAUSE) begin
      lvl_r <= pwdata[7];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one pulse after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prio2_zero: assert property (acc && !pwrite && paddr == `IPC_OFF_PRIO2 |->
    prdata[5:4] == 2'b00 && prdata[2] == 1'b0) else $error("unused priority bits read 1");
  a_cause_zero: assert property (acc && !pwrite && paddr == `IPC_OFF_RCAUSE |->
    prdata[6:5] == 2'b00) else $error("unused cause bits read 1");
  a_single_level: assert property (!lvl_r && !$past(lvl_r) |-> !irq_low_r)
    else $error("low request in single-level mode");
  a_wake_sleep: assert property (wake_r |-> $past(core_sleeping))
    else $error("wake while core awake");
  a_wake_vector: assert property (wake_vector_r |-> wake_r)
    else $error("vector without wake");
  a_shadow_copy: assert property (irq_taken |=> shadow_working_r == $past(working_register)
    && shadow_status_r == $past(status_register) && shadow_bank_r == $past(bank_select_register))
    else $error("context not copied to shadow");
  a_stack_push: assert property (irq_taken && !return_evt |=> stack_overflow_r
    || stack_top_r == $past(return_pc)) else $error("return address not pushed");
endmodule // ipc_irq_chk

bind ipc_irq_ctrl ipc_irq_chk u_chk (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .core_sleeping, .irq_taken, .return_evt, .return_pc,
  .working_register, .status_register, .bank_select_register, .irq_low_r, .wake_r,
  .wake_vector_r, .shadow_working_r, .shadow_status_r, .shadow_bank_r, .stack_top_r,
  .stack_overflow_r);
`default_nettype wire

//--- verif/ipc_irq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_irq_ctrl_tb;
  logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq_high_r, irq_low_r, wake_r, wake_vector_r, stack_overflow_r;
  logic [7:0] periph_flag_1 = 0, periph_flag_2 = 0, periph_flag_3 = 0;
  logic [7:0] periph_en_1 = 0, periph_en_2 = 0, periph_en_3 = 0;
  logic [3:0] ext_pin = 0, portb_hi_pin = 0, lat = 0;
  logic [15:0] timer0_count = 0;
  logic instr_reset_evt = 0, watchdog_timeout_evt = 0, sleep_entry_evt = 0;
  logic watchdog_clear_evt = 0, por_evt = 0, brown_out_evt = 0, core_sleeping = 0;
  logic irq_taken, return_evt;
  logic [20:0] return_pc, stack_top_r;
  logic [7:0] working_register, status_register, shadow_working_r, shadow_status_r;
  logic [3:0] bank_select_register, shadow_bank_r;
  int miscompares = 0, n_checks = 0, cyc = 0;

  always #50 clk_sys = ~clk_sys;

  ipc_irq_ctrl dut (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .periph_flag_1, .periph_flag_2, .periph_flag_3, .periph_en_1,
    .periph_en_2, .periph_en_3, .ext_pin, .portb_hi_pin, .timer0_count, .instr_reset_evt,
    .watchdog_timeout_evt, .sleep_entry_evt, .watchdog_clear_evt, .por_evt, .brown_out_evt,
    .core_sleeping, .irq_taken, .return_evt, .return_pc, .working_register, .status_register,
    .bank_select_register, .irq_high_r, .irq_low_r, .wake_r, .wake_vector_r,
    .shadow_working_r, .shadow_status_r, .shadow_bank_r, .stack_top_r, .stack_overflow_r);
  ipc_core_model core (.clk_sys, .rstn, .lat, .irq_high_r, .irq_low_r, .irq_taken,
    .return_evt, .return_pc, .working_register, .status_register, .bank_select_register);

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Bus and compare helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, rd);
  endtask
  // Ten cycles cover the synchroniser, flag and request stages
  task automatic wt;
    repeat (10) @(posedge clk_sys);
  endtask
  // Waits for the core to take a request, then checks what was saved
  task automatic chk_ctx;
    logic [7:0] w;
    logic [20:0] pc;
    while (irq_taken !== 1'b1) begin
      @(posedge clk_sys);
    end
    w = working_register;
    pc = return_pc;
    @(posedge clk_sys);
    chk("shadow working", {24'h0, w}, {24'h0, shadow_working_r});
    chk("stack top", {11'h0, pc}, {11'h0, stack_top_r});
  endtask
  task automatic chk_req(input logic h, input logic l);
    chk("high request", {31'h0, h}, {31'h0, irq_high_r});
    chk("low request", {31'h0, l}, {31'h0, irq_low_r});
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    rdc(`IPC_OFF_PRIO1, 32'h0000_00FF);
    rdc(`IPC_OFF_PRIO2, 32'h0000_00CB);
    rdc(`IPC_OFF_PRIO3, 32'h0000_00FF);
    rdc(`IPC_OFF_RCAUSE, 32'h0000_001C);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
    rdc(`IPC_OFF_STATUS, 32'h0000_0000);
    apb(1'b1, `IPC_OFF_STATUS, 32'h0000_00FF);
    chk("status write error", 32'h0000_0001, {31'h0, er});
    apb(1'b1, `IPC_OFF_PRIO1, 32'h0000_0000);
    rdc(`IPC_OFF_PRIO1, 32'h0000_0000);
    apb(1'b1, `IPC_OFF_PRIO2, 32'h0000_00FF);
    rdc(`IPC_OFF_PRIO2, 32'h0000_00CB);
    apb(1'b1, `IPC_OFF_PRIO2, 32'h0000_0000);
    apb(1'b1, `IPC_OFF_PRIO3, 32'h0000_005A);
    rdc(`IPC_OFF_PRIO3, 32'h0000_005A);
    apb(1'b1, `IPC_OFF_RCAUSE, 32'h0000_00FF);
    rdc(`IPC_OFF_RCAUSE, 32'h0000_009F);
    $display("t_regs done");
  endtask
  task automatic t_ext;
    apb(1'b1, `IPC_OFF_THIRD, 32'h0000_0008);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_00D0);
    ext_pin[0] <= 1'b1;
    wt;
    chk_req(1'b1, 1'b0);
    ext_pin[0] <= 1'b0;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_00D2);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_00D0);
    ext_pin[1] <= 1'b1;
    wt;
    chk_req(1'b0, 1'b1);
    rdc(`IPC_OFF_THIRD, 32'h0000_0009);
    apb(1'b1, `IPC_OFF_THIRD, 32'h0000_0049);
    wt;
    chk_req(1'b1, 1'b0);
    apb(1'b1, `IPC_OFF_THIRD, 32'h0000_0008);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_00C0);
    apb(1'b1, `IPC_OFF_SECOND, 32'h0000_003F);
    ext_pin[0] <= 1'b1;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_00C0);
    ext_pin[0] <= 1'b0;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_00C2);
    chk_req(1'b0, 1'b0);
    core_sleeping <= 1'b1;
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0012);
    wt;
    chk("wake", 32'h0000_0001, {31'h0, wake_r});
    chk("wake vector", 32'h0000_0000, {31'h0, wake_vector_r});
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0092);
    wt;
    chk("wake vector", 32'h0000_0001, {31'h0, wake_vector_r});
    core_sleeping <= 1'b0;
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0000);
    $display("t_ext done");
  endtask
  task automatic t_periph;
    periph_flag_1 <= 8'h01;
    periph_en_1 <= 8'h01;
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_00C0);
    wt;
    chk_req(1'b0, 1'b1);
    chk_ctx;
    apb(1'b1, `IPC_OFF_PRIO1, 32'h0000_0001);
    wt;
    chk_req(1'b1, 1'b0);
    periph_flag_1 <= 8'h00;
    periph_flag_2 <= 8'h80;
    periph_en_2 <= 8'h80;
    apb(1'b1, `IPC_OFF_PRIO2, 32'h0000_0080);
    wt;
    chk_req(1'b1, 1'b0);
    periph_flag_2 <= 8'h00;
    periph_flag_3 <= 8'h01;
    periph_en_3 <= 8'h01;
    wt;
    chk_req(1'b0, 1'b1);
    apb(1'b1, `IPC_OFF_RCAUSE, 32'h0000_0013);
    wt;
    chk_req(1'b1, 1'b0);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0080);
    wt;
    chk_req(1'b0, 1'b0);
    periph_flag_3 <= 8'h00;
    $display("t_periph done");
  endtask
  task automatic t_misc;
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0000);
    timer0_count <= 16'h00FF;
    @(posedge clk_sys);
    timer0_count <= 16'h0100;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_0004);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0000);
    apb(1'b1, `IPC_OFF_TMR0CFG, 32'h0000_0001);
    rdc(`IPC_OFF_TMR0CFG, 32'h0000_0001);
    timer0_count <= 16'h01FF;
    @(posedge clk_sys);
    timer0_count <= 16'h0200;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_0000);
    timer0_count <= 16'hFFFF;
    @(posedge clk_sys);
    timer0_count <= 16'h0000;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_0004);
    apb(1'b1, `IPC_OFF_RCAUSE, 32'h0000_0093);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_00E4);
    wt;
    chk_req(1'b1, 1'b0);
    apb(1'b1, `IPC_OFF_SECOND, 32'h0000_003B);
    wt;
    chk_req(1'b0, 1'b1);
    apb(1'b1, `IPC_OFF_MAIN, 32'h0000_0000);
    portb_hi_pin[2] <= 1'b1;
    wt;
    rdc(`IPC_OFF_MAIN, 32'h0000_0001);
    {instr_reset_evt, watchdog_timeout_evt, sleep_entry_evt} <= 3'b111;
    {por_evt, brown_out_evt} <= 2'b11;
    @(posedge clk_sys);
    {instr_reset_evt, watchdog_timeout_evt, sleep_entry_evt, por_evt, brown_out_evt} <= 5'h0;
    wt;
    rdc(`IPC_OFF_RCAUSE, 32'h0000_0080);
    watchdog_clear_evt <= 1'b1;
    @(posedge clk_sys);
    watchdog_clear_evt <= 1'b0;
    wt;
    rdc(`IPC_OFF_RCAUSE, 32'h0000_008C);
    $display("t_misc done");
  endtask

  // Hang guard: the whole run needs about 400 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_ext;
    t_periph;
    lat <= 4'd7;
    t_misc;
    end_sim;
  end
endmodule // ipc_irq_ctrl_tb
`default_nettype wire
